/* bench/mwc_host_model.sv */
// Host controller model driving the serial control bus
`timescale 1ns/10ps
`default_nettype none
module mwc_host_model (
    input  wire logic i_clk,
    output logic      o_sclk,
    output logic      o_select_n,
    output logic      o_cdata
);
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_cdata = 1'b1;
    end
    // Each level held two clocks; the slave needs only one clock per level to see an edge
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_cdata = b[i];
            repeat (2) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (2) @(negedge i_clk);
        end
    endtask
    task automatic send(input logic [7:0] adr, input logic [7:0] dat, input logic with_dat);
        if (adr == mwc_pkg::ADDR_SETUP) begin
            dat[7] = 1'b0;
            if (dat[3:2] == 2'h3) begin
                dat[3:2] = 2'h0;
            end
        end
        @(negedge i_clk);
        o_select_n = 1'b0;
        put_byte(adr);
        if (with_dat) begin
            put_byte(dat);
        end
        o_sclk = 1'b0;
        repeat (3) @(negedge i_clk);
        o_select_n = 1'b1;
        // Released line must not keep showing the last bit
        o_cdata = ~o_cdata;
        repeat (2) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

/* bench/mwc_props.sv */
// Port checks for the control register bank
`timescale 1ns/10ps
`default_nettype none
module mwc_props (
    input wire logic       I_MCLK,
    input wire logic       I_RST,
    input wire logic       I_SELECT_N,
    input wire logic       O_RELAY_PULLDOWN_PIN_O,
    input wire logic       O_RELAY_PULLDOWN_PIN_OE,
    input wire logic [1:0] O_DETECT_MODE,
    input wire logic       O_ANALOG_LOOP,
    input wire logic       O_RX_AMP_CONNECT,
    input wire logic       O_DIGITAL_LOOP,
    input wire logic [1:0] O_CRYSTAL_SELECT,
    input wire logic       O_ZERO_POWER,
    input wire logic       O_OSC_ENABLE,
    input wire logic [7:0] O_TONE_CTRL,
    input wire logic [7:0] O_TX_BYTE,
    input wire logic       O_TX_BYTE_STROBE,
    input wire logic       O_LOOP_TX_READY,
    input wire logic       O_LOOP_RX_READY
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    chk_relay_sink: assert property (O_RELAY_PULLDOWN_PIN_O == 1'b0)
        else $error("relay pin value not low");
    chk_zero_power: assert property (O_ZERO_POWER == (O_CRYSTAL_SELECT == 2'h0) && O_OSC_ENABLE != O_ZERO_POWER)
        else $error("zero power state wrong");
    chk_analog_loop: assert property (O_ANALOG_LOOP != O_RX_AMP_CONNECT)
        else $error("amp not cut in analog loop");
    chk_loop_single: assert property (!(O_ANALOG_LOOP && O_DIGITAL_LOOP))
        else $error("two loop paths at once");
    // No bus activity, so the checked register outputs may not move
    chk_regs_hold: assert property (I_SELECT_N && $past(I_SELECT_N) |-> $stable({O_RELAY_PULLDOWN_PIN_OE,
        O_DETECT_MODE, O_CRYSTAL_SELECT, O_TONE_CTRL, O_TX_BYTE}))
        else $error("register moved while idle");
    chk_strobe_pulse: assert property (O_TX_BYTE_STROBE |=> !O_TX_BYTE_STROBE)
        else $error("strobe longer than one cycle");
    chk_rx_pulse: assert property (O_LOOP_RX_READY |=> !O_LOOP_RX_READY)
        else $error("loop ready longer than one cycle");
    chk_tx_busy: assert property (O_TX_BYTE_STROBE && O_DIGITAL_LOOP && $past(O_LOOP_TX_READY) |-> !O_LOOP_TX_READY)
        else $error("loop stays ready after byte");
endmodule
bind modem_write_control_regs mwc_props u_props (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_SELECT_N(I_SELECT_N),
    .O_RELAY_PULLDOWN_PIN_O(O_RELAY_PULLDOWN_PIN_O), .O_RELAY_PULLDOWN_PIN_OE(O_RELAY_PULLDOWN_PIN_OE),
    .O_DETECT_MODE(O_DETECT_MODE), .O_ANALOG_LOOP(O_ANALOG_LOOP), .O_RX_AMP_CONNECT(O_RX_AMP_CONNECT),
    .O_DIGITAL_LOOP(O_DIGITAL_LOOP), .O_CRYSTAL_SELECT(O_CRYSTAL_SELECT), .O_ZERO_POWER(O_ZERO_POWER),
    .O_OSC_ENABLE(O_OSC_ENABLE), .O_TONE_CTRL(O_TONE_CTRL), .O_TX_BYTE(O_TX_BYTE),
    .O_TX_BYTE_STROBE(O_TX_BYTE_STROBE), .O_LOOP_TX_READY(O_LOOP_TX_READY), .O_LOOP_RX_READY(O_LOOP_RX_READY));
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the control register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clk, rst, sclk, sel_n, cdata;
    logic       relay_o, relay_oe, aloop, amp, dloop, zp, osc, strb;
    logic       toe, band, pbw, rxen, txr, rxr;
    logic [1:0] det, xtal;
    logic [7:0] tone, gain, txb, fmt, txmod, rxdem, irq, rxd;
    int         mismatches = 0;
    int         check_count = 0;
    int         strobes = 0;

    mwc_host_model host (.i_clk(clk), .o_sclk(sclk), .o_select_n(sel_n), .o_cdata(cdata));
    // Short bit period keeps loopback runs brief
    modem_write_control_regs #(.BIT_PERIOD_CYCLES(4)) DUT (.I_MCLK(clk), .I_RST(rst), .I_SERIAL_CLK(sclk),
        .I_SELECT_N(sel_n), .I_COMMAND_DATA(cdata), .O_RELAY_PULLDOWN_PIN_O(relay_o),
        .O_RELAY_PULLDOWN_PIN_OE(relay_oe), .O_DETECT_MODE(det), .O_ANALOG_LOOP(aloop), .O_RX_AMP_CONNECT(amp),
        .O_DIGITAL_LOOP(dloop), .O_CRYSTAL_SELECT(xtal), .O_ZERO_POWER(zp), .O_OSC_ENABLE(osc),
        .O_TONE_CTRL(tone), .O_GAIN_CTRL(gain), .O_TX_BYTE(txb), .O_TX_BYTE_STROBE(strb), .O_CHAR_FORMAT(fmt),
        .O_TX_MOD_CTRL(txmod), .O_RX_DEMOD_CTRL(rxdem), .O_IRQ_MASK(irq), .O_TRANSMIT_OUTPUT_ENABLE(toe),
        .O_BAND_SELECT(band), .O_PROGRESS_BANDWIDTH_SELECT(pbw), .O_RX_DEMOD_ENABLE(rxen),
        .O_LOOP_TX_READY(txr), .O_LOOP_RX_READY(rxr), .O_LOOP_RX_DATA(rxd));

    // Counted mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        if (strb === 1'b1) begin
            strobes++;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [63:0] setup_exp(input logic [7:0] v);
        return {54'h0, v[6], v[5:4], v[3:2] == 2'h1, v[3:2] != 2'h1, v[3:2] == 2'h2, v[1:0], v[1:0] == 2'h0,
            v[1:0] != 2'h0};
    endfunction
    function automatic logic [63:0] setup_now();
        return {54'h0, relay_oe, det, aloop, amp, dloop, xtal, zp, osc};
    endfunction
    function automatic logic [63:0] regs_now();
        return {8'h0, tone, gain, txb, fmt, txmod, rxdem, irq};
    endfunction

    task automatic t_reset();
        check(setup_now(), setup_exp(8'h00));
        check(regs_now(), 64'h0);
        check({53'h0, relay_o, txr, rxr, rxd}, 64'h0);
    endtask
    task automatic t_setup();
        logic [7:0] vals [6];
        vals = '{8'h41, 8'h15, 8'h2a, 8'h32, 8'h37, 8'h00};
        foreach (vals[i]) begin
            host.send(mwc_pkg::ADDR_SETUP, vals[i], 1'b1);
            check(setup_now(), setup_exp(vals[i]));
        end
    endtask
    task automatic t_regs();
        logic [7:0] adr [7];
        logic [7:0] dat [7];
        adr = '{8'he1, 8'he2, 8'he3, 8'he4, 8'he7, 8'he8, 8'hee};
        dat = '{8'h5a, 8'hc3, 8'ha5, 8'h3c, 8'h41, 8'h03, 8'h7e};
        host.send(mwc_pkg::ADDR_SETUP, 8'h41, 1'b1);
        foreach (adr[i]) begin
            host.send(adr[i], dat[i], 1'b1);
        end
        check(regs_now(), 64'h5ac3a53c41037e);
        check({60'h0, toe, band, pbw, rxen}, 64'hd);
        check(64'(strobes), 64'h1);
        // Unmapped address, then an address with no data byte
        host.send(8'he5, 8'hff, 1'b1);
        host.send(mwc_pkg::ADDR_TONE, 8'h00, 1'b0);
        check(regs_now(), 64'h5ac3a53c41037e);
        host.send(mwc_pkg::ADDR_GENERAL_RESET, 8'h00, 1'b0);
        check(regs_now(), 64'h0);
        check(setup_now(), setup_exp(8'h00));
    endtask
    task automatic t_loop();
        logic [7:0] b [2];
        int n;
        b = '{8'ha5, 8'h5a};
        // Crystal bits nonzero, else the bit timer stalls
        host.send(mwc_pkg::ADDR_SETUP, 8'h09, 1'b1);
        foreach (b[i]) begin
            check({63'h0, txr}, 64'h1);
            host.send(mwc_pkg::ADDR_TX_BYTE, b[i], 1'b1);
            for (n = 0; n < 200 && rxr !== 1'b1; n++) begin
                @(negedge clk);
            end
            check({63'h0, n < 200}, 64'h1);
            check({56'h0, rxd}, {56'h0, b[i]});
        end
        check(64'(strobes), 64'h3);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_setup();
        t_regs();
        t_loop();
        summarize();
    end
    // About 1400 cycles expected; generous margin
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire

/* verilog/modem_write_control_regs.sv */
// Write-only control register bank of the 1200 bit/s modem, serial bus slave
// Function
// - General reset is an address byte only
// - General reset clears all write-only registers
// - Setup bit 6 enables relay pull-down sink
// - Setup bits 5:4 pick receive detector mode
// - Loopback 00 means no internal loop
// - Loopback 01 routes transmit gain to receive
// - Loopback 10 serialises transmit byte into receiver
// - Address byte then one data byte stored
// - Setup bits 1:0 pick crystal or zero-power
// - Zero-power stops oscillator and most functions
`timescale 1ns/10ps
`default_nettype none
module modem_write_control_regs #(
    parameter int BIT_PERIOD_CYCLES = mwc_pkg::BIT_PERIOD_CYCLES
) (
    input  wire logic       I_MCLK,
    input  wire logic       I_RST,
    input  wire logic       I_SERIAL_CLK,
    input  wire logic       I_SELECT_N,
    input  wire logic       I_COMMAND_DATA,
    output logic            O_RELAY_PULLDOWN_PIN_O,
    output logic            O_RELAY_PULLDOWN_PIN_OE,
    output logic [1:0]      O_DETECT_MODE,
    output logic            O_ANALOG_LOOP,
    output logic            O_RX_AMP_CONNECT,
    output logic            O_DIGITAL_LOOP,
    output logic [1:0]      O_CRYSTAL_SELECT,
    output logic            O_ZERO_POWER,
    output logic            O_OSC_ENABLE,
    output logic [7:0]      O_TONE_CTRL,
    output logic [7:0]      O_GAIN_CTRL,
    output logic [7:0]      O_TX_BYTE,
    output logic            O_TX_BYTE_STROBE,
    output logic [7:0]      O_CHAR_FORMAT,
    output logic [7:0]      O_TX_MOD_CTRL,
    output logic [7:0]      O_RX_DEMOD_CTRL,
    output logic [7:0]      O_IRQ_MASK,
    output logic            O_TRANSMIT_OUTPUT_ENABLE,
    output logic            O_BAND_SELECT,
    output logic            O_PROGRESS_BANDWIDTH_SELECT,
    output logic            O_RX_DEMOD_ENABLE,
    output logic            O_LOOP_TX_READY,
    output logic            O_LOOP_RX_READY,
    output logic [7:0]      O_LOOP_RX_DATA
);
    if (BIT_PERIOD_CYCLES < 2) begin : g_bad_period
        $error("modem_write_control_regs: BIT_PERIOD_CYCLES must be at least 2");
    end

    typedef struct packed {
        mwc_pkg::mwc_phase_t phase;
        logic [2:0]          idx;
        logic [7:0][7:0]     regs;
        logic                tx_strobe;
        logic                lb_active;
        logic [2:0]          lb_cnt;
        logic [7:0]          lb_shift;
        logic [7:0]          lb_rx;
        logic [7:0]          rx_data;
        logic                rx_ready;
    } mwc_state_t;

    localparam mwc_state_t CTRL_RESET = '{
        phase:     mwc_pkg::MWC_PH_ADDR,
        idx:       3'h0,
        regs:      {mwc_pkg::NUM_REGS{mwc_pkg::REG_RESET_VALUE}},
        tx_strobe: 1'b0,
        lb_active: 1'b0,
        lb_cnt:    3'h0,
        lb_shift:  8'h00,
        lb_rx:     8'h00,
        rx_data:   8'h00,
        rx_ready:  1'b0
    };

    mwc_state_t s;
    mwc_state_t next_s;

    logic       byte_valid;
    logic [7:0] byte_data;
    logic       bit_tick;
    logic [3:0] dec;
    logic [7:0] setup;
    logic [1:0] loop_code;
    logic [1:0] xtal_code;
    logic       zero_power;

    mwc_serial_rx u_rx (
        .i_clk        (I_MCLK),
        .i_rst        (I_RST),
        .i_sclk       (I_SERIAL_CLK),
        .i_select_n   (I_SELECT_N),
        .i_cdata      (I_COMMAND_DATA),
        .o_byte_valid (byte_valid),
        .o_byte       (byte_data)
    );

    // Bit clock runs only while a loopback byte is in flight
    mwc_bit_timer #(
        .DIVIDE (BIT_PERIOD_CYCLES)
    ) u_bit_timer (
        .i_clk    (I_MCLK),
        .i_rst    (I_RST),
        .i_enable (s.lb_active && !zero_power),
        .o_tick   (bit_tick)
    );

    assign setup      = s.regs[mwc_pkg::IDX_SETUP];
    assign loop_code  = setup[mwc_pkg::SETUP_LOOP_HI:mwc_pkg::SETUP_LOOP_LO];
    assign xtal_code  = setup[mwc_pkg::SETUP_XTAL_HI:mwc_pkg::SETUP_XTAL_LO];
    assign zero_power = (xtal_code == mwc_pkg::XTAL_ZERO_POWER);
    assign dec        = mwc_pkg::mwc_reg_decode(byte_data);

    always_comb begin
        next_s           = s;
        next_s.tx_strobe = 1'b0;
        next_s.rx_ready  = 1'b0;

        // Digital loopback serialiser, LSB first into the receive buffer
        if (loop_code != mwc_pkg::LOOP_DIGITAL) begin
            next_s.lb_active = 1'b0;
            next_s.lb_cnt    = 3'h0;
        end else if (s.lb_active && bit_tick) begin
            next_s.lb_rx    = {s.lb_shift[0], s.lb_rx[7:1]};
            next_s.lb_shift = {1'b0, s.lb_shift[7:1]};
            if (s.lb_cnt == 3'(mwc_pkg::BYTE_BITS - 1)) begin
                next_s.lb_active = 1'b0;
                next_s.lb_cnt    = 3'h0;
                next_s.rx_data   = {s.lb_shift[0], s.lb_rx[7:1]};
                next_s.rx_ready  = 1'b1;
            end else begin
                next_s.lb_cnt = s.lb_cnt + 3'h1;
            end
        end

        if (I_SELECT_N) begin
            // End of transaction, next byte is an address again
            next_s.phase = mwc_pkg::MWC_PH_ADDR;
        end else if (byte_valid) begin
            unique case (s.phase)
                mwc_pkg::MWC_PH_ADDR: begin
                    if (byte_data == mwc_pkg::ADDR_GENERAL_RESET) begin
                        // Acts at once, no data byte awaited
                        next_s.regs      = CTRL_RESET.regs;
                        next_s.lb_active = 1'b0;
                        next_s.lb_cnt    = 3'h0;
                        next_s.phase     = mwc_pkg::MWC_PH_SKIP;
                    end else if (dec[3]) begin
                        next_s.idx   = dec[2:0];
                        next_s.phase = mwc_pkg::MWC_PH_DATA;
                    end else begin
                        next_s.phase = mwc_pkg::MWC_PH_SKIP;
                    end
                end
                mwc_pkg::MWC_PH_DATA: begin
                    next_s.regs[s.idx] = byte_data;
                    next_s.phase       = mwc_pkg::MWC_PH_SKIP;
                    if (s.idx == mwc_pkg::IDX_TX_BYTE) begin
                        next_s.tx_strobe = 1'b1;
                        // A byte written while one is still shifting is not looped
                        if (loop_code == mwc_pkg::LOOP_DIGITAL && !s.lb_active) begin
                            next_s.lb_shift  = byte_data;
                            next_s.lb_active = 1'b1;
                            next_s.lb_cnt    = 3'h0;
                        end
                    end
                end
                mwc_pkg::MWC_PH_SKIP: begin
                    // Extra bytes of a transaction are dropped
                    next_s.phase = mwc_pkg::MWC_PH_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            s <= CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Open-drain relay driver only ever pulls low
    assign O_RELAY_PULLDOWN_PIN_O  = 1'b0;
    assign O_RELAY_PULLDOWN_PIN_OE = setup[mwc_pkg::SETUP_RELAY_BIT];

    assign O_DETECT_MODE = setup[mwc_pkg::SETUP_DET_HI:mwc_pkg::SETUP_DET_LO];

    // Reserved code 11 falls back to normal routing
    assign O_ANALOG_LOOP    = (loop_code == mwc_pkg::LOOP_ANALOG);
    assign O_RX_AMP_CONNECT = (loop_code != mwc_pkg::LOOP_ANALOG);
    assign O_DIGITAL_LOOP   = (loop_code == mwc_pkg::LOOP_DIGITAL);

    assign O_CRYSTAL_SELECT = xtal_code;
    assign O_ZERO_POWER     = zero_power;
    assign O_OSC_ENABLE     = !zero_power;

    assign O_TONE_CTRL      = s.regs[mwc_pkg::IDX_TONE];
    assign O_GAIN_CTRL      = s.regs[mwc_pkg::IDX_GAIN];
    assign O_TX_BYTE        = s.regs[mwc_pkg::IDX_TX_BYTE];
    assign O_TX_BYTE_STROBE = s.tx_strobe;
    assign O_CHAR_FORMAT    = s.regs[mwc_pkg::IDX_CHAR_FORMAT];
    assign O_TX_MOD_CTRL    = s.regs[mwc_pkg::IDX_TX_MOD];
    assign O_RX_DEMOD_CTRL  = s.regs[mwc_pkg::IDX_RX_DEMOD];
    assign O_IRQ_MASK       = s.regs[mwc_pkg::IDX_IRQ_MASK];

    assign O_TRANSMIT_OUTPUT_ENABLE    = s.regs[mwc_pkg::IDX_TX_MOD][mwc_pkg::TXMOD_OUTPUT_EN_BIT];
    assign O_BAND_SELECT               = s.regs[mwc_pkg::IDX_RX_DEMOD][mwc_pkg::RXDEM_BAND_BIT];
    assign O_PROGRESS_BANDWIDTH_SELECT = s.regs[mwc_pkg::IDX_RX_DEMOD][mwc_pkg::RXDEM_PROGRESS_BW_BIT];
    assign O_RX_DEMOD_ENABLE           = s.regs[mwc_pkg::IDX_RX_DEMOD][mwc_pkg::RXDEM_ENABLE_BIT];

    // Loopback handshake toward the receive side
    assign O_LOOP_TX_READY = (loop_code == mwc_pkg::LOOP_DIGITAL) && !s.lb_active;
    assign O_LOOP_RX_READY = s.rx_ready;
    assign O_LOOP_RX_DATA  = s.rx_data;
endmodule
`default_nettype wire

/* verilog/mwc_bit_timer.sv */
// Modem bit-rate enable divider, restarts whenever it is disabled
`timescale 1ns/10ps
`default_nettype none
module mwc_bit_timer #(
    parameter int DIVIDE = mwc_pkg::BIT_PERIOD_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_enable,
    output logic      o_tick
);
    localparam int CW = $clog2(DIVIDE);

    if (DIVIDE < 2) begin : g_bad_divide
        $error("mwc_bit_timer: DIVIDE must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } mwc_tmr_state_t;

    localparam mwc_tmr_state_t TMR_RESET = '0;

    mwc_tmr_state_t s;
    mwc_tmr_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!i_enable) begin
            next_s.cnt = '0;
        end else if (s.cnt == CW'(DIVIDE - 1)) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= TMR_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Gated with enable so a late tick never leaks after a stop
    assign o_tick = s.tick && i_enable;
endmodule
`default_nettype wire

/* verilog/mwc_pkg.sv */
// Constants and types shared by the modem write-only control register bank
`default_nettype none
package mwc_pkg;

    // Address bytes of the serial control bus
    localparam logic [7:0] ADDR_GENERAL_RESET = 8'h01;
    localparam logic [7:0] ADDR_SETUP         = 8'he0;
    localparam logic [7:0] ADDR_TONE          = 8'he1;
    localparam logic [7:0] ADDR_GAIN          = 8'he2;
    localparam logic [7:0] ADDR_TX_BYTE       = 8'he3;
    localparam logic [7:0] ADDR_CHAR_FORMAT   = 8'he4;
    localparam logic [7:0] ADDR_TX_MOD        = 8'he7;
    localparam logic [7:0] ADDR_RX_DEMOD      = 8'he8;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'hee;

    // Storage slots of the write-only registers
    localparam int         NUM_REGS         = 8;
    localparam logic [2:0] IDX_SETUP        = 3'h0;
    localparam logic [2:0] IDX_TONE         = 3'h1;
    localparam logic [2:0] IDX_GAIN         = 3'h2;
    localparam logic [2:0] IDX_TX_BYTE      = 3'h3;
    localparam logic [2:0] IDX_CHAR_FORMAT  = 3'h4;
    localparam logic [2:0] IDX_TX_MOD       = 3'h5;
    localparam logic [2:0] IDX_RX_DEMOD     = 3'h6;
    localparam logic [2:0] IDX_IRQ_MASK     = 3'h7;
    localparam logic [7:0] REG_RESET_VALUE  = 8'h00;

    // Setup register fields
    localparam int SETUP_RELAY_BIT   = 6;
    localparam int SETUP_DET_HI      = 5;
    localparam int SETUP_DET_LO      = 4;
    localparam int SETUP_LOOP_HI     = 3;
    localparam int SETUP_LOOP_LO     = 2;
    localparam int SETUP_XTAL_HI     = 1;
    localparam int SETUP_XTAL_LO     = 0;

    // Modulator and demodulator control fields
    localparam int TXMOD_OUTPUT_EN_BIT  = 6;
    localparam int RXDEM_PROGRESS_BW_BIT = 6;
    localparam int RXDEM_ENABLE_BIT     = 1;
    localparam int RXDEM_BAND_BIT       = 0;

    localparam logic [1:0] LOOP_NORMAL    = 2'h0;
    localparam logic [1:0] LOOP_ANALOG    = 2'h1;
    localparam logic [1:0] LOOP_DIGITAL   = 2'h2;
    localparam logic [1:0] XTAL_ZERO_POWER = 2'h0;

    // Timing
    localparam int CLK_HZ            = 50_000_000;
    localparam int MODEM_BIT_RATE    = 1200;
    localparam int BIT_PERIOD_CYCLES = CLK_HZ / MODEM_BIT_RATE;
    localparam int BYTE_BITS         = 8;

    typedef enum logic [1:0] {
        MWC_DET_PSK_CARRIER,
        MWC_DET_CALL_PROGRESS,
        MWC_DET_ANSWER_TONE,
        MWC_DET_OFF
    } mwc_detect_t;

    typedef enum logic [1:0] {
        MWC_PH_ADDR,
        MWC_PH_DATA,
        MWC_PH_SKIP
    } mwc_phase_t;

    // Hit flag in bit 3, storage slot in bits 2:0
    function automatic logic [3:0] mwc_reg_decode(input logic [7:0] addr);
        logic [3:0] r;
        r = 4'h0;
        unique case (addr)
            ADDR_SETUP:       r = {1'b1, IDX_SETUP};
            ADDR_TONE:        r = {1'b1, IDX_TONE};
            ADDR_GAIN:        r = {1'b1, IDX_GAIN};
            ADDR_TX_BYTE:     r = {1'b1, IDX_TX_BYTE};
            ADDR_CHAR_FORMAT: r = {1'b1, IDX_CHAR_FORMAT};
            ADDR_TX_MOD:      r = {1'b1, IDX_TX_MOD};
            ADDR_RX_DEMOD:    r = {1'b1, IDX_RX_DEMOD};
            ADDR_IRQ_MASK:    r = {1'b1, IDX_IRQ_MASK};
            default:          r = 4'h0;
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire

/* verilog/mwc_serial_rx.sv */
// Byte receiver for the serial control bus, MSB first on serial clock rising edges
`timescale 1ns/10ps
`default_nettype none
module mwc_serial_rx (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_sclk,
    input  wire logic       i_select_n,
    input  wire logic       i_cdata,
    output logic            o_byte_valid,
    output logic [7:0]      o_byte
);
    typedef struct packed {
        logic       sclk_prev;
        logic [2:0] cnt;
        logic [6:0] shift;
        logic       valid;
        logic [7:0] data;
    } mwc_rx_state_t;

    localparam mwc_rx_state_t RX_RESET = '0;

    mwc_rx_state_t s;
    mwc_rx_state_t next_s;

    always_comb begin
        next_s           = s;
        next_s.valid     = 1'b0;
        next_s.sclk_prev = i_sclk;
        if (i_select_n) begin
            // Deselect drops any partial byte
            next_s.cnt = 3'h0;
        end else if (i_sclk && !s.sclk_prev) begin
            if (s.cnt == 3'(mwc_pkg::BYTE_BITS - 1)) begin
                next_s.data  = {s.shift, i_cdata};
                next_s.valid = 1'b1;
                next_s.cnt   = 3'h0;
            end else begin
                next_s.shift = {s.shift[5:0], i_cdata};
                next_s.cnt   = s.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= RX_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_byte_valid = s.valid;
    assign o_byte       = s.data;
endmodule
`default_nettype wire
